// File: hdl/rcs_pkg.sv
package rcs_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	localparam logic [3:0] OFS_IRQ_STATUS = 4'h0;
	localparam logic [3:0] OFS_IRQ_CLEAR  = 4'h1;
	localparam logic [3:0] OFS_IRQ_ENABLE = 4'h2;
	localparam logic [3:0] OFS_SUPV_CTRL  = 4'h3;
	localparam logic [3:0] OFS_USART_PRE  = 4'h4;
	localparam logic [3:0] OFS_USART_CS   = 4'h5;
	localparam logic [3:0] OFS_USART_RX   = 4'h6;
	localparam logic [3:0] OFS_USART_INT  = 4'h7;
	localparam logic [3:0] OFS_CMP_SEL    = 4'h8;
	localparam logic [3:0] OFS_STATE      = 4'h9;

	localparam int OPT_POR_BIT  = 6;
	localparam int OPT_OSC_HI   = 4;
	localparam int OPT_OSC_LO   = 3;
	localparam int OPT_SUPV_BIT = 2;

	localparam int IRQ_W   = 3;
	localparam int IRQ_POR = 0;
	localparam int IRQ_EXT = 1;
	localparam int IRQ_CM  = 2;

	localparam int SUPV_CM_BIT = 2;
	localparam logic [1:0] SUPV_WIN_MAX = 2'h3;
	localparam logic [7:0] SUPV_RST_ON  = 8'h07;
	localparam logic [7:0] SUPV_RST_OFF = 8'h00;

	localparam int TXE_BIT = 0;
	localparam logic [7:0] USART_CS_RST = 8'h01;
	localparam logic [7:0] REG_CLEARED  = 8'h00;

	localparam logic [11:0] IDLE_PRESET = 12'hfff;
	localparam logic [11:0] IDLE_ZERO   = 12'h000;

	localparam int CM_MIN_CYC = 16;
	localparam int CM_MAX_CYC = 32;
	localparam logic [4:0] CM_LAST = 5'(CM_MIN_CYC - 1);

	typedef enum logic [1:0] {
		OSC_EXT_CLK,
		OSC_RC,
		OSC_XTAL_NOBIAS,
		OSC_XTAL_BIAS
	} rcs_osc_e;

	typedef enum logic [1:0] {
		SEQ_SUPPLY_LOW,
		SEQ_STRETCH,
		SEQ_RUN
	} rcs_seq_e;

	typedef struct packed {
		logic [7:0] prescaler;
		logic [7:0] ctrl_status;
		logic [7:0] rx_ctrl;
		logic [7:0] int_ctrl;
	} rcs_usart_s;

	typedef struct packed {
		rcs_osc_e mode;
		logic     clock_output_drive;
		logic     bias_enable;
		logic     g7_general_input;
	} rcs_osc_s;

endpackage

// File: hdl/rcs_sync.sv
`timescale 1ns/1ps
module rcs_sync #(
	parameter int WIDTH = 1
) (
	input  logic             core_clk,
	input  logic             sys_rst,
	input  logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_reg;

	// The first stage feeds only the second one.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stage1_reg <= '0;
			sync_out   <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end

endmodule

// File: hdl/rcs_top.sv
// Behaviour
// - Reset clears USART state, sets tx-empty.
// - Warm reset keeps RAM; power-on leaves undefined.
// - Reset sets service window max, arms monitor.
// - Supervision and monitor silent during reset.
// - Slow clock drives error pin low.
// - Reset pin also ends halt state.
// - Power-on reset asserts as supply rises.
// - Power-on detector presets idle timer 0fff.
// - Internal reset held until idle timer underflows.
// - Power-on reset initialises like pin reset.
// - No further power-on reset while supply good.
// - Power-on leaves data and RAM undefined.
// - Two option bits choose oscillator source.
// - External and R/C modes free bit-7 pin.
// - Crystal modes drive clock output pin.
// - Option bit 6 enables power-on reset.
// - Option bit 2 low enables supervision pin.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module rcs_top (
	input  logic                         core_clk,
	input  logic                         sys_rst,
	input  logic                         reset_n_pin,
	input  logic                         supply_ok,
	input  logic                         clock_ok,
	input  logic [7:0]                   option_word,
	input  logic                         port_g_bit7_pin,
	input  logic                         halt_active,
	input  logic [rcs_pkg::ADDR_W-1:0]   reg_addr,
	input  logic [rcs_pkg::DATA_W-1:0]   reg_wdata,
	input  logic                         reg_wr,
	input  logic                         reg_rd,
	output logic [rcs_pkg::DATA_W-1:0]   reg_rdata,
	output logic                         irq,
	output logic                         internal_rst,
	output logic                         halt_exit,
	output logic                         ram_valid,
	output rcs_pkg::rcs_usart_s          usart_state,
	output logic [7:0]                   comparator_select,
	output rcs_pkg::rcs_osc_s            osc_cfg,
	output logic                         clock_output_pin_oe,
	output logic                         port_g_bit7_in,
	output logic                         port_g_bit1_pin_out,
	output logic                         port_g_bit1_pin_oe,
	output logic                         port_g_bit1_pullup
);

	function automatic rcs_pkg::rcs_osc_s osc_decode(input logic [1:0] sel);
		rcs_pkg::rcs_osc_s cfg;
		cfg = '0;
		case (sel)
			2'h0: cfg.mode = rcs_pkg::OSC_EXT_CLK;
			2'h1: cfg.mode = rcs_pkg::OSC_RC;
			2'h2: cfg.mode = rcs_pkg::OSC_XTAL_NOBIAS;
			default: cfg.mode = rcs_pkg::OSC_XTAL_BIAS;
		endcase
		cfg.clock_output_drive = sel[1];
		cfg.bias_enable        = sel[1] & sel[0];
		cfg.g7_general_input   = ~sel[1];
		return cfg;
	endfunction

	logic                    rst_n_s;
	logic                    supply_ok_s;
	logic                    clock_ok_s;
	logic                    g7_s;
	logic [7:0]              opt_s;

	rcs_sync #(.WIDTH(12)) u_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.async_in ({reset_n_pin, supply_ok, clock_ok, port_g_bit7_pin,
			option_word}),
		.sync_out ({rst_n_s, supply_ok_s, clock_ok_s, g7_s, opt_s})
	);

	// Pin reset is active low and must stay low one cycle; a shorter
	// glitch may be missed by the synchroniser.
	wire ext_rst   = ~rst_n_s;
	wire por_en    = opt_s[rcs_pkg::OPT_POR_BIT];
	wire supv_en   = ~opt_s[rcs_pkg::OPT_SUPV_BIT];
	wire [1:0] osc_sel = {opt_s[rcs_pkg::OPT_OSC_HI],
		opt_s[rcs_pkg::OPT_OSC_LO]};

	rcs_pkg::rcs_seq_e seq_reg;
	rcs_pkg::rcs_seq_e seq_next;
	logic [11:0]       idle_countdown_timer_reg;
	logic              ext_rst_d_reg;
	logic              cm_err_reg;
	logic [4:0]        cm_cnt_reg;
	logic [7:0]        supv_ctrl_reg;
	logic [rcs_pkg::IRQ_W-1:0] irq_status_reg;
	logic [rcs_pkg::IRQ_W-1:0] irq_enable_reg;

	wire idle_zero = idle_countdown_timer_reg == rcs_pkg::IDLE_ZERO;
	wire por_rise  = (seq_reg == rcs_pkg::SEQ_SUPPLY_LOW) && por_en &&
		supply_ok_s;
	wire ext_rise  = ext_rst & ~ext_rst_d_reg;
	wire cm_armed  = supv_en & supv_ctrl_reg[rcs_pkg::SUPV_CM_BIT];
	wire cm_set    = ~internal_rst & cm_armed & ~clock_ok_s & ~cm_err_reg;
	// Next value of the reset net; the error pin is quietened in the same
	// edge that raises reset instead of one cycle after it.
	wire rst_next  = ext_rst | (seq_next != rcs_pkg::SEQ_RUN);
	wire cm_drive  = cm_err_reg & ~rst_next;

	// Power-on sequencing. The detector only acts on a rise of the supply
	// flag, so once the timer has run out nothing restarts the stretch
	// until the supply has dropped below threshold first.
	always_comb begin
		seq_next = seq_reg;
		case (seq_reg)
			rcs_pkg::SEQ_SUPPLY_LOW: begin
				if (!por_en) begin
					seq_next = rcs_pkg::SEQ_RUN;
				end else if (supply_ok_s) begin
					seq_next = rcs_pkg::SEQ_STRETCH;
				end
			end
			rcs_pkg::SEQ_STRETCH: begin
				if (por_en && !supply_ok_s) begin
					seq_next = rcs_pkg::SEQ_SUPPLY_LOW;
				end else if (!por_en || idle_zero) begin
					seq_next = rcs_pkg::SEQ_RUN;
				end
			end
			rcs_pkg::SEQ_RUN: begin
				if (por_en && !supply_ok_s) begin
					seq_next = rcs_pkg::SEQ_SUPPLY_LOW;
				end
			end
			default: seq_next = rcs_pkg::SEQ_SUPPLY_LOW;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			seq_reg <= rcs_pkg::SEQ_SUPPLY_LOW;
		end else begin
			seq_reg <= seq_next;
		end
	end

	// The idle timer runs freely at the instruction rate.
	always_ff @(posedge core_clk) begin
		if (sys_rst || por_rise) begin
			idle_countdown_timer_reg <= rcs_pkg::IDLE_PRESET;
		end else begin
			idle_countdown_timer_reg <= idle_countdown_timer_reg - 12'h001;
		end
	end

	// One reset net for USART, comparator, supervision and monitor state, so both sources act alike. The pin
	// synchroniser reads low during reset, so the edge detector starts high
	// or every reset release would look like a pin reset.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			internal_rst  <= 1'b1;
			ext_rst_d_reg <= 1'b1;
		end else begin
			internal_rst  <= rst_next;
			ext_rst_d_reg <= ext_rst;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			halt_exit <= 1'b0;
		end else begin
			halt_exit <= ext_rise & halt_active;
		end
	end

	// RAM is never cleared; only its trust flag is dropped by a power-on.
	always_ff @(posedge core_clk) begin
		if (sys_rst || por_rise) begin
			ram_valid <= 1'b0;
		end else if (reg_wr && reg_addr == rcs_pkg::OFS_STATE &&
			reg_wdata[0]) begin
			ram_valid <= 1'b1;
		end
	end

	// Clock monitor: error lasts until the clock has been good for the
	// minimum count; the input synchroniser adds two more cycles.
	always_ff @(posedge core_clk) begin
		if (sys_rst || internal_rst) begin
			cm_err_reg <= 1'b0;
			cm_cnt_reg <= 5'h00;
		end else if (cm_set) begin
			cm_err_reg <= 1'b1;
			cm_cnt_reg <= 5'h00;
		end else if (cm_err_reg && !clock_ok_s) begin
			cm_cnt_reg <= 5'h00;
		end else if (cm_err_reg) begin
			cm_cnt_reg <= cm_cnt_reg + 5'h01;
			if (cm_cnt_reg == rcs_pkg::CM_LAST) begin
				cm_err_reg <= 1'b0;
			end
		end
	end

	wire wr_hit_ctrl = reg_wr & ~internal_rst;

	always_ff @(posedge core_clk) begin
		if (sys_rst || internal_rst) begin
			supv_ctrl_reg <= supv_en ? rcs_pkg::SUPV_RST_ON :
				rcs_pkg::SUPV_RST_OFF;
		end else if (wr_hit_ctrl && reg_addr == rcs_pkg::OFS_SUPV_CTRL) begin
			supv_ctrl_reg <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || internal_rst) begin
			usart_state.prescaler   <= rcs_pkg::REG_CLEARED;
			usart_state.ctrl_status <= rcs_pkg::USART_CS_RST;
			usart_state.rx_ctrl     <= rcs_pkg::REG_CLEARED;
			usart_state.int_ctrl    <= rcs_pkg::REG_CLEARED;
			comparator_select       <= rcs_pkg::REG_CLEARED;
		end else if (wr_hit_ctrl) begin
			case (reg_addr)
				rcs_pkg::OFS_USART_PRE: usart_state.prescaler   <= reg_wdata;
				rcs_pkg::OFS_USART_CS:  usart_state.ctrl_status <= reg_wdata;
				rcs_pkg::OFS_USART_RX:  usart_state.rx_ctrl     <= reg_wdata;
				rcs_pkg::OFS_USART_INT: usart_state.int_ctrl    <= reg_wdata;
				rcs_pkg::OFS_CMP_SEL:   comparator_select       <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Pin configuration follows the option word.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			osc_cfg             <= '0;
			clock_output_pin_oe <= 1'b0;
			port_g_bit7_in      <= 1'b0;
			port_g_bit1_pin_out <= 1'b1;
			port_g_bit1_pin_oe  <= 1'b0;
			port_g_bit1_pullup  <= 1'b0;
		end else begin
			osc_cfg             <= osc_decode(osc_sel);
			clock_output_pin_oe <= osc_sel[1];
			port_g_bit7_in      <= ~osc_sel[1] & g7_s;
			port_g_bit1_pin_out <= ~cm_drive;
			port_g_bit1_pin_oe  <= supv_en & cm_drive;
			port_g_bit1_pullup  <= supv_en;
		end
	end

	// Status bits are sticky; a set in the clearing cycle wins.
	wire [rcs_pkg::IRQ_W-1:0] irq_events = {cm_set, ext_rise, por_rise};
	wire [rcs_pkg::IRQ_W-1:0] irq_clear  =
		(reg_wr && reg_addr == rcs_pkg::OFS_IRQ_CLEAR) ?
		reg_wdata[rcs_pkg::IRQ_W-1:0] : '0;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_status_reg <= '0;
			irq_enable_reg <= '0;
			irq            <= 1'b0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
			if (reg_wr && reg_addr == rcs_pkg::OFS_IRQ_ENABLE) begin
				irq_enable_reg <= reg_wdata[rcs_pkg::IRQ_W-1:0];
			end
			irq <= |(((irq_status_reg & ~irq_clear) | irq_events) &
				irq_enable_reg);
		end
	end

	wire [7:0] state_word = {1'b0, cm_err_reg, osc_sel, por_en, supv_en,
		internal_rst, ram_valid};
	logic [7:0] rd_mux;

	always_comb begin
		case (reg_addr)
			rcs_pkg::OFS_IRQ_STATUS: rd_mux = {5'h00, irq_status_reg};
			rcs_pkg::OFS_IRQ_ENABLE: rd_mux = {5'h00, irq_enable_reg};
			rcs_pkg::OFS_SUPV_CTRL:  rd_mux = supv_ctrl_reg;
			rcs_pkg::OFS_USART_PRE:  rd_mux = usart_state.prescaler;
			rcs_pkg::OFS_USART_CS:   rd_mux = usart_state.ctrl_status;
			rcs_pkg::OFS_USART_RX:   rd_mux = usart_state.rx_ctrl;
			rcs_pkg::OFS_USART_INT:  rd_mux = usart_state.int_ctrl;
			rcs_pkg::OFS_CMP_SEL:    rd_mux = comparator_select;
			rcs_pkg::OFS_STATE:      rd_mux = state_word;
			default:                 rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_usart_reset_value: assert property (
		internal_rst |=> usart_state.ctrl_status == rcs_pkg::USART_CS_RST
			&& usart_state.prescaler == 8'h00)
		else $error("USART state not at reset value after reset");

	a_ram_warm_keep: assert property (
		ram_valid && ext_rst && seq_reg == rcs_pkg::SEQ_RUN &&
			supply_ok_s |=> ram_valid)
		else $error("RAM trust flag lost on warm reset");

	a_supv_window_max: assert property (
		internal_rst && supv_en |=>
			supv_ctrl_reg[1:0] == rcs_pkg::SUPV_WIN_MAX &&
			supv_ctrl_reg[rcs_pkg::SUPV_CM_BIT])
		else $error("Service window or monitor bit not set by reset");

	a_cm_quiet_reset: assert property (
		internal_rst ##1 internal_rst |-> !cm_err_reg && !port_g_bit1_pin_oe)
		else $error("Clock monitor error during reset");

	a_cm_error_holds: assert property (
		$rose(cm_err_reg) ##1 (clock_ok_s && !internal_rst) [*8] |->
			cm_err_reg)
		else $error("Clock monitor error released too early");

	a_cm_release_late: assert property (
		$fell(cm_err_reg) && !$past(internal_rst) |->
			$past(clock_ok_s) && $past(clock_ok_s, 16))
		else $error("Clock monitor error released before full count");

	a_halt_exit_pulse: assert property (
		$rose(ext_rst) && halt_active |=> halt_exit ##1 !halt_exit)
		else $error("Halt not ended by reset pin");

	a_por_preset_load: assert property (
		por_rise |=> idle_countdown_timer_reg == 12'hfff &&
			seq_reg == rcs_pkg::SEQ_STRETCH)
		else $error("Idle timer not preset by power-on");

	a_por_stretch_hold: assert property (
		seq_reg == rcs_pkg::SEQ_STRETCH && !idle_zero |=> internal_rst)
		else $error("Internal reset released before underflow");

	a_no_extra_por: assert property (
		seq_reg == rcs_pkg::SEQ_RUN && supply_ok_s |=> !por_rise)
		else $error("Extra power-on reset with supply good");

	a_reset_or_sources: assert property (
		ext_rst |=> internal_rst ##1 (ext_rst ? internal_rst : 1'b1))
		else $error("Pin reset did not reach internal reset");

	a_crystal_drive: assert property (
		osc_sel[1] ##1 osc_sel[1] |-> clock_output_pin_oe &&
			!port_g_bit7_in)
		else $error("Crystal mode does not drive clock output");

endmodule

// File: verification/rcs_rst_src.sv
`timescale 1ns/1ps
// Board reset source: pulls the active-low pin for a number of cycles.
module rcs_rst_src (
	input  wire logic       core_clk,
	input  wire logic       pulse_req,
	input  wire logic [7:0] pulse_len,
	output wire logic       reset_n_pin
);
	logic [7:0] hold_reg = 8'h00;

	// Shorter requests are stretched so the pin is never low for under a cycle.
	always @(posedge core_clk) begin
		if (hold_reg != 8'h00) begin
			hold_reg <= hold_reg - 8'h01;
		end else if (pulse_req) begin
			hold_reg <= (pulse_len == 8'h00) ? 8'h01 : pulse_len;
		end
	end

	// Idle level is high because the board pulls the pin up.
	assign reset_n_pin = (hold_reg == 8'h00);
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic                core_clk = 1'b0;
	logic                sys_rst = 1'b1;
	logic                supply_ok = 1'b1;
	logic                clock_ok = 1'b1;
	logic [7:0]          option_word = 8'h00;
	logic                port_g_bit7_pin = 1'b1;
	logic                halt_active = 1'b0;
	logic [3:0]          reg_addr = 4'h0;
	logic [7:0]          reg_wdata = 8'h00;
	logic                reg_wr = 1'b0;
	logic                reg_rd = 1'b0;
	logic                pulse_req = 1'b0;
	logic [7:0]          pulse_len = 8'h03;
	wire logic           reset_n_pin;
	logic [7:0]          reg_rdata;
	logic [7:0]          comparator_select;
	logic                irq, internal_rst, halt_exit, ram_valid;
	logic                clock_output_pin_oe, port_g_bit7_in;
	logic                port_g_bit1_pin_out, port_g_bit1_pin_oe;
	logic                port_g_bit1_pullup;
	rcs_pkg::rcs_usart_s usart_state;
	rcs_pkg::rcs_osc_s   osc_cfg;
	int                  errors = 0;
	int                  tests_run = 0;
	int                  halt_seen = 0;
	int                  n;

	always #12.5 core_clk = ~core_clk;

	rcs_rst_src src (.core_clk, .pulse_req, .pulse_len, .reset_n_pin);

	rcs_top uut (.core_clk, .sys_rst, .reset_n_pin, .supply_ok, .clock_ok,
		.option_word, .port_g_bit7_pin, .halt_active, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .internal_rst,
		.halt_exit, .ram_valid, .usart_state, .comparator_select,
		.osc_cfg, .clock_output_pin_oe, .port_g_bit7_in,
		.port_g_bit1_pin_out, .port_g_bit1_pin_oe, .port_g_bit1_pullup);

	always @(posedge core_clk) begin
		if (halt_exit === 1'b1) begin
			halt_seen <= halt_seen + 1;
		end
	end

	task automatic finish_test();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so look there.
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(32'(reg_rdata), 32'(exp));
	endtask

	task automatic wait_rst(input logic v, input int lim, output int cnt);
		cnt = 0;
		while (internal_rst !== v) begin
			@(posedge core_clk);
			#1;
			cnt++;
			if (cnt > lim) begin
				errors++;
				$display("BAD %0t: internal reset stuck", $time);
				finish_test();
			end
		end
	endtask

	task automatic pin_reset();
		int c;
		@(posedge core_clk);
		pulse_req <= 1'b1;
		@(posedge core_clk);
		pulse_req <= 1'b0;
		wait_rst(1'b1, 10, c);
		chk(32'(port_g_bit1_pin_out), 32'h1);
		chk(32'(port_g_bit1_pin_oe), 32'h0);
		wait_rst(1'b0, 20, c);
	endtask

	task automatic defaults(input logic [7:0] supv);
		rd(rcs_pkg::OFS_USART_PRE, 8'h00);
		rd(rcs_pkg::OFS_USART_CS, 8'h01);
		rd(rcs_pkg::OFS_USART_RX, 8'h00);
		rd(rcs_pkg::OFS_USART_INT, 8'h00);
		rd(rcs_pkg::OFS_CMP_SEL, 8'h00);
		rd(rcs_pkg::OFS_SUPV_CTRL, supv);
		chk(32'(usart_state), 32'h0001_0000);
		chk(32'(comparator_select), 32'h0);
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		errors++;
		finish_test();
	end

	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		wait_rst(1'b0, 50, n);
		defaults(8'h07);
		wr(rcs_pkg::OFS_USART_PRE, 8'h5a);
		wr(rcs_pkg::OFS_USART_CS, 8'h00);
		wr(rcs_pkg::OFS_USART_RX, 8'h33);
		wr(rcs_pkg::OFS_USART_INT, 8'h44);
		wr(rcs_pkg::OFS_CMP_SEL, 8'h66);
		wr(rcs_pkg::OFS_STATE, 8'h01);
		rd(rcs_pkg::OFS_STATE, 8'h05);
		wr(rcs_pkg::OFS_IRQ_CLEAR, 8'h07);
		halt_active <= 1'b1;
		pin_reset();
		halt_active <= 1'b0;
		chk(32'(halt_seen), 32'h1);
		defaults(8'h07);
		rd(rcs_pkg::OFS_STATE, 8'h05);
		rd(rcs_pkg::OFS_IRQ_STATUS, 8'h02);
		// Interrupt: raise, mask, unmask, clear.
		wr(rcs_pkg::OFS_IRQ_ENABLE, 8'h02);
		repeat (2) @(posedge core_clk);
		#1;
		chk(32'(irq), 32'h1);
		wr(rcs_pkg::OFS_IRQ_ENABLE, 8'h00);
		repeat (2) @(posedge core_clk);
		#1;
		chk(32'(irq), 32'h0);
		wr(rcs_pkg::OFS_IRQ_ENABLE, 8'h02);
		wr(rcs_pkg::OFS_IRQ_CLEAR, 8'h02);
		repeat (2) @(posedge core_clk);
		#1;
		chk(32'(irq), 32'h0);
		wr(rcs_pkg::OFS_IRQ_STATUS, 8'hff);
		rd(rcs_pkg::OFS_IRQ_STATUS, 8'h00);
		rd(4'hf, 8'h00);
		// Every clock option, with supervision off in the odd ones.
		for (int i = 0; i < 4; i++) begin
			option_word <= 8'(i << 3) | ((i % 2 == 1) ? 8'h04 : 8'h00);
			port_g_bit7_pin <= (i != 0);
			pin_reset();
			chk(32'(osc_cfg.mode), 32'(i));
			chk(32'(osc_cfg.clock_output_drive), 32'(i / 2));
			chk(32'(clock_output_pin_oe), 32'(i / 2));
			chk(32'(osc_cfg.bias_enable), 32'(i == 3));
			chk(32'(port_g_bit7_in), 32'(i == 1));
			chk(32'(osc_cfg.g7_general_input), 32'(i < 2));
			chk(32'(port_g_bit1_pullup), 32'(i % 2 == 0));
			rd(rcs_pkg::OFS_SUPV_CTRL, (i % 2 == 1) ? 8'h00 : 8'h07);
		end
		// A slow clock at the end of reset must pull the error pin low.
		option_word <= 8'h00;
		clock_ok <= 1'b0;
		pin_reset();
		repeat (4) @(posedge core_clk);
		#1;
		chk(32'(port_g_bit1_pin_out), 32'h0);
		chk(32'(port_g_bit1_pin_oe), 32'h1);
		rd(rcs_pkg::OFS_IRQ_STATUS, 8'h06);
		// Reset again while the error pin is pulled low: it must go quiet.
		pin_reset();
		repeat (3) @(posedge core_clk);
		clock_ok <= 1'b1;
		n = 0;
		while (port_g_bit1_pin_out !== 1'b1 && n < 60) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(32'(n >= 16 && n <= 32), 32'h1);
		// Power-on: stretch through the idle countdown, RAM not trusted.
		wr(rcs_pkg::OFS_USART_CS, 8'h00);
		wr(rcs_pkg::OFS_STATE, 8'h01);
		wr(rcs_pkg::OFS_IRQ_CLEAR, 8'h07);
		option_word <= 8'h40;
		repeat (4) @(posedge core_clk);
		supply_ok <= 1'b0;
		wait_rst(1'b1, 10, n);
		repeat (20) @(posedge core_clk);
		#1;
		chk(32'(internal_rst), 32'h1);
		supply_ok <= 1'b1;
		wait_rst(1'b0, 4200, n);
		chk(32'(n >= 4096 && n <= 4106), 32'h1);
		rd(rcs_pkg::OFS_STATE, 8'h0c);
		rd(rcs_pkg::OFS_IRQ_STATUS, 8'h01);
		rd(rcs_pkg::OFS_USART_CS, 8'h01);
		chk(32'(ram_valid), 32'h0);
		n = 0;
		repeat (200) begin
			@(posedge core_clk);
			#1;
			n = n + ((internal_rst !== 1'b0) ? 1 : 0);
		end
		chk(32'(n), 32'h0);
		chk(32'(halt_seen), 32'h1);
		finish_test();
	end
endmodule
